// ### design/sdtmr_tick_gen.sv
`timescale 1ns/1ps
`include "sdtmr_params.svh"

module sdtmr_tick_gen #(
  parameter int DIV_W = 17
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  sdtmr_tick_if.gen   tk
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [3:0]       mid;
    logic [6:0]       slow;
    logic             t_fast;
    logic             t_mid;
    logic             t_slow;
  } sdtmr_tick_state_t;

  localparam logic [3:0] MID_LAST  = 4'(`SDTMR_TB_MID_RATIO - 1);
  localparam logic [6:0] SLOW_LAST = 7'(`SDTMR_TB_SLOW_RATIO - 1);

  sdtmr_tick_state_t st_r;
  sdtmr_tick_state_t st_nxt;

  // ========================================
  // divider chain: fast tick, then by ten, then by a hundred
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.t_fast = 1'b0;
    st_nxt.t_mid  = 1'b0;
    st_nxt.t_slow = 1'b0;
    if (st_r.cnt >= tk.div_cycles - DIV_W'(1))
    begin
      st_nxt.cnt    = '0;
      st_nxt.t_fast = 1'b1;
      if (st_r.mid == MID_LAST)
      begin
        st_nxt.mid   = 4'h0;
        st_nxt.t_mid = 1'b1;
        if (st_r.slow == SLOW_LAST)
        begin
          st_nxt.slow   = 7'h00;
          st_nxt.t_slow = 1'b1;
        end
        else
          st_nxt.slow = st_r.slow + 7'h01;
      end
      else
        st_nxt.mid = st_r.mid + 4'h1;
    end
    else
      st_nxt.cnt = st_r.cnt + DIV_W'(1);
  end

  // ========================================
  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tk.tick_1ms  = st_r.t_fast;
  assign tk.tick_10ms = st_r.t_mid;
  assign tk.tick_1s   = st_r.t_slow;

endmodule : sdtmr_tick_gen

// ### design/sdtmr_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "sdtmr_params.svh"

//
// Overview of operation
// - element is three words: control/status, preset, elapsed count
// - control word: enable bit 15, timing bit 14, done bit 13
// - preset takes 0 to 32767 and marks interval completion
// - elapsed count tallies time-base intervals, kept in 0 to 32767
// - done sets on reaching preset in on-delay and retentive modes only
// - time base per element: 1 ms, 10 ms or 1 s per count
// - clear operation zeroes elapsed count and the done and timing flags
// - off-delay times while rung is false, output drops after preset
// - retentive mode delays turn-on and keeps count when interrupted
// - on-delay counts while true, stops at preset, zeroes when false
// - off-delay counts while false, zeroes when rung becomes true
// - retentive keeps count across false rung, resumes from it
// - timing set while counting below preset (rung true, false in off-delay), drops when rung changes or preset reached
//

module sdtmr_top #(
  parameter int ADDR_W   = 3,
  parameter int DATA_W   = 32,
  parameter int DIV_W    = 17,
  parameter int PEND_W   = 12,
  parameter int MS_CYCLES = `SDTMR_CLK_HZ / 1000 * `SDTMR_TB_FAST_MS
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output      logic [DATA_W-1:0] RDATA,
  input  wire logic              SCAN_EVAL,
  input  wire logic              RUNG_TRUE,
  output      logic              ENABLE_OUT,
  output      logic              TIMING_OUT,
  output      logic              DONE_OUT,
  output      logic              IRQ
);

  // ========================================
  // state of the element
  typedef struct packed {
    logic                    en;
    logic                    tt;
    logic                    dn;
    logic [PEND_W-1:0]       pend;
    logic [14:0]             preset;
    logic [14:0]             acc;
    sdtmr_pkg::sdtmr_mode_t  mode;
    sdtmr_pkg::sdtmr_tbase_t tbase;
    logic [2:0]              status;
    logic [2:0]              mask;
    logic [DIV_W-1:0]        div;
    logic [DATA_W-1:0]       rdata;
    logic                    irq;
  } sdtmr_state_t;

  localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(MS_CYCLES);
  localparam logic [PEND_W-1:0] LIM_1MS =
    PEND_W'(`SDTMR_MAX_SCAN_MS / `SDTMR_TB_FAST_MS);
  localparam logic [PEND_W-1:0] LIM_10MS =
    PEND_W'(`SDTMR_MAX_SCAN_MS / (`SDTMR_TB_FAST_MS * `SDTMR_TB_MID_RATIO));
  localparam logic [PEND_W-1:0] LIM_1S =
    PEND_W'(`SDTMR_MAX_SCAN_MS /
            (`SDTMR_TB_FAST_MS * `SDTMR_TB_MID_RATIO * `SDTMR_TB_SLOW_RATIO));
  localparam logic [15:0] COUNT_MAX = 16'(`SDTMR_COUNT_MAX);

  sdtmr_state_t st_r;
  sdtmr_state_t st_nxt;
  logic         rst_meta_r;
  logic         rst_sync_r;

  sdtmr_tick_if #(.DIV_W(DIV_W)) tick_bus ();

  // ========================================
  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ========================================
  // time-base ticks
  sdtmr_tick_gen #(
    .DIV_W (DIV_W)
  ) u_tick (
    .clk   (CORE_CLK),
    .rst_n (rst_sync_r),
    .tk    (tick_bus.gen)
  );

  assign tick_bus.div_cycles = st_r.div;

  // ========================================
  // tick of the selected time base
  logic tick_sel;
  logic [PEND_W-1:0] pend_lim;

  always_comb
  begin
    case (st_r.tbase)
      sdtmr_pkg::SDTMR_TB_1MS:
      begin
        tick_sel = tick_bus.tick_1ms;
        pend_lim = LIM_1MS;
      end
      sdtmr_pkg::SDTMR_TB_10MS:
      begin
        tick_sel = tick_bus.tick_10ms;
        pend_lim = LIM_10MS;
      end
      sdtmr_pkg::SDTMR_TB_1S:
      begin
        tick_sel = tick_bus.tick_1s;
        pend_lim = LIM_1S;
      end
      default:
      begin
        tick_sel = tick_bus.tick_1ms;
        pend_lim = LIM_1MS;
      end
    endcase
  end

  // ========================================
  // register read mux
  logic [DATA_W-1:0] rd_word;

  always_comb
  begin
    rd_word = '0;
    case (ADDR)
      `SDTMR_OFS_CTRL_STAT:
      begin
        rd_word[`SDTMR_BIT_ENABLE] = st_r.en;
        rd_word[`SDTMR_BIT_TIMING] = st_r.tt;
        rd_word[`SDTMR_BIT_DONE]   = st_r.dn;
        rd_word[PEND_W-1:0]        = st_r.pend;  // internal use field
      end
      `SDTMR_OFS_PRESET:
        rd_word[14:0] = st_r.preset;
      `SDTMR_OFS_ELAPSED:
        rd_word[14:0] = st_r.acc;
      `SDTMR_OFS_CONFIG:
      begin
        rd_word[`SDTMR_CFG_MODE_LSB +: 2]  = st_r.mode;
        rd_word[`SDTMR_CFG_TBASE_LSB +: 2] = st_r.tbase;
      end
      `SDTMR_OFS_IRQ_STATUS:
        rd_word[2:0] = st_r.status;
      `SDTMR_OFS_IRQ_MASK:
        rd_word[2:0] = st_r.mask;
      `SDTMR_OFS_DIVIDER:
        rd_word[DIV_W-1:0] = st_r.div;
      default:
        rd_word = '0;
    endcase
  end

  // ========================================
  // decoded strobes
  logic wr_cfg;
  logic clear_op;

  assign wr_cfg   = WR_STB && (ADDR == `SDTMR_OFS_CONFIG);
  assign clear_op = wr_cfg && WDATA[`SDTMR_CFG_CLEAR_BIT];

  // ========================================
  // next state of the element
  logic [15:0]       sum;
  logic [14:0]       acc_base;
  logic              dn_base;
  logic              tt_base;
  logic [PEND_W-1:0] pend_base;
  logic [2:0]        ev;

  always_comb
  begin
    st_nxt  = st_r;
    ev      = 3'h0;
    st_nxt.rdata = RD_STB ? rd_word : '0;

    // pending ticks since last scan, held at the scan limit
    pend_base = st_r.pend;
    if (tick_sel)
    begin
      if (st_r.pend >= pend_lim)
        ev[`SDTMR_EV_OVERRUN] = 1'b1;
      else
        pend_base = st_r.pend + PEND_W'(1);
    end

    // clear operation zeroes count and flags first
    acc_base = st_r.acc;
    dn_base  = st_r.dn;
    tt_base  = st_r.tt;
    if (clear_op)
    begin
      acc_base  = 15'h0000;
      dn_base   = 1'b0;
      tt_base   = 1'b0;
      pend_base = '0;
    end

    st_nxt.acc  = acc_base;
    st_nxt.dn   = dn_base;
    st_nxt.tt   = tt_base;
    st_nxt.pend = pend_base;
    sum = {1'b0, acc_base} + 16'(st_r.pend);

    // scan evaluation applies the rung on top of the cleared state
    if (SCAN_EVAL)
    begin
      st_nxt.en   = RUNG_TRUE;
      st_nxt.pend = '0;
      case (st_r.mode)
        sdtmr_pkg::SDTMR_OFF_DELAY_MODE:
        begin
          if (RUNG_TRUE)
          begin
            st_nxt.acc = 15'h0000;
            st_nxt.dn  = 1'b1;
            st_nxt.tt  = 1'b0;
          end
          else if (dn_base)
          begin
            // ticks count only if the rung was already false
            if (!st_r.en && acc_base < st_r.preset)
              st_nxt.acc = (sum > {1'b0, st_r.preset}) ?
                           st_r.preset : sum[14:0];
            if (st_nxt.acc >= st_r.preset)
            begin
              st_nxt.dn = 1'b0;
              st_nxt.tt = 1'b0;
            end
            else
              st_nxt.tt = 1'b1;
          end
        end
        sdtmr_pkg::SDTMR_RETENTIVE_ON_DELAY_MODE:
        begin
          if (RUNG_TRUE)
          begin
            if (st_r.en && acc_base < st_r.preset)
              st_nxt.acc = (sum > {1'b0, st_r.preset}) ?
                           st_r.preset : sum[14:0];
            if (st_nxt.acc >= st_r.preset)
              st_nxt.dn = 1'b1;
            st_nxt.tt = (st_nxt.acc < st_r.preset);
          end
          else
            st_nxt.tt = 1'b0;
        end
        default:
        begin
          // on-delay
          if (RUNG_TRUE)
          begin
            if (st_r.en && acc_base < st_r.preset)
              st_nxt.acc = (sum > {1'b0, st_r.preset}) ?
                           st_r.preset : sum[14:0];
            st_nxt.dn = (st_nxt.acc >= st_r.preset);
            st_nxt.tt = (st_nxt.acc < st_r.preset);
          end
          else
          begin
            st_nxt.acc = 15'h0000;
            st_nxt.dn  = 1'b0;
            st_nxt.tt  = 1'b0;
          end
        end
      endcase
    end

    // rising flag events
    if (st_nxt.dn && !st_r.dn)
      ev[`SDTMR_EV_DONE] = 1'b1;
    if (st_nxt.tt && !st_r.tt)
      ev[`SDTMR_EV_TIMING] = 1'b1;

    // register writes; counts held within 0 to 32767
    if (WR_STB)
    begin
      case (ADDR)
        `SDTMR_OFS_PRESET:
          st_nxt.preset = WDATA[14:0];
        `SDTMR_OFS_ELAPSED:
          if (!SCAN_EVAL)
            st_nxt.acc = WDATA[14:0];
        `SDTMR_OFS_CONFIG:
        begin
          st_nxt.mode  = sdtmr_pkg::sdtmr_mode_t'(
                           WDATA[`SDTMR_CFG_MODE_LSB +: 2]);
          st_nxt.tbase = sdtmr_pkg::sdtmr_tbase_t'(
                           WDATA[`SDTMR_CFG_TBASE_LSB +: 2]);
        end
        `SDTMR_OFS_IRQ_MASK:
          st_nxt.mask = WDATA[2:0];
        `SDTMR_OFS_DIVIDER:
          if (WDATA[DIV_W-1:0] != '0)
            st_nxt.div = WDATA[DIV_W-1:0];
        default:
          st_nxt.mask = st_r.mask;
      endcase
    end

    // sticky status: read clears, new event wins
    if (RD_STB && ADDR == `SDTMR_OFS_IRQ_STATUS)
      st_nxt.status = ev;
    else
      st_nxt.status = st_r.status | ev;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  // ========================================
  // state register
  always_ff @(posedge CORE_CLK or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      st_r        <= '0;
      st_r.preset <= `SDTMR_RST_PRESET;
      st_r.acc    <= `SDTMR_RST_ELAPSED;
      st_r.mask   <= `SDTMR_RST_MASK;
      st_r.mode   <= sdtmr_pkg::SDTMR_ON_DELAY_MODE;
      st_r.tbase  <= sdtmr_pkg::SDTMR_TB_1MS;
      st_r.div    <= DIV_RST;
    end
    else
      st_r <= st_nxt;
  end

  // ========================================
  // outputs straight from flops
  assign RDATA      = st_r.rdata;
  assign ENABLE_OUT = st_r.en;
  assign TIMING_OUT = st_r.tt;
  assign DONE_OUT   = st_r.dn;
  assign IRQ        = st_r.irq;

  // unused upper limit kept for range documentation
  logic count_in_range;
  assign count_in_range = ({1'b0, st_r.acc} <= COUNT_MAX);

endmodule : sdtmr_top

// ### pkg/sdtmr_params.svh
`ifndef SDTMR_PARAMS_SVH
`define SDTMR_PARAMS_SVH

// ========================================
// register indices
`define SDTMR_OFS_CTRL_STAT   3'h0
`define SDTMR_OFS_PRESET      3'h1
`define SDTMR_OFS_ELAPSED     3'h2
`define SDTMR_OFS_CONFIG      3'h3
`define SDTMR_OFS_IRQ_STATUS  3'h4
`define SDTMR_OFS_IRQ_MASK    3'h5
`define SDTMR_OFS_DIVIDER     3'h6

// ========================================
// control word field positions
`define SDTMR_BIT_ENABLE      15
`define SDTMR_BIT_TIMING      14
`define SDTMR_BIT_DONE        13
`define SDTMR_INTERNAL_MSB    12

// ========================================
// config word field positions
`define SDTMR_CFG_MODE_LSB    0
`define SDTMR_CFG_TBASE_LSB   2
`define SDTMR_CFG_CLEAR_BIT   8

// ========================================
// event bits of status and mask
`define SDTMR_EV_DONE         0
`define SDTMR_EV_TIMING       1
`define SDTMR_EV_OVERRUN      2

// ========================================
// reset values
`define SDTMR_RST_PRESET      15'h0000
`define SDTMR_RST_ELAPSED     15'h0000
`define SDTMR_RST_MASK        3'h0

// ========================================
// timing
`define SDTMR_CLK_HZ          125000000
`define SDTMR_TB_FAST_MS      1
`define SDTMR_TB_MID_RATIO    10
`define SDTMR_TB_SLOW_RATIO   100
`define SDTMR_MAX_SCAN_MS     2550
`define SDTMR_COUNT_MAX       32767

`endif

// ### pkg/sdtmr_pkg.sv
package sdtmr_pkg;

  // ========================================
  // timer modes and time bases
  typedef enum logic [1:0] {
    SDTMR_ON_DELAY_MODE,
    SDTMR_OFF_DELAY_MODE,
    SDTMR_RETENTIVE_ON_DELAY_MODE
  } sdtmr_mode_t;

  typedef enum logic [1:0] {
    SDTMR_TB_1MS,
    SDTMR_TB_10MS,
    SDTMR_TB_1S
  } sdtmr_tbase_t;

endpackage : sdtmr_pkg

// ### pkg/sdtmr_tick_if.sv
`timescale 1ns/1ps

// time-base divider setting and tick pulses
interface sdtmr_tick_if #(parameter int DIV_W = 17);
  logic [DIV_W-1:0] div_cycles;
  logic             tick_1ms;
  logic             tick_10ms;
  logic             tick_1s;

  modport gen  (input div_cycles, output tick_1ms, tick_10ms, tick_1s);
  modport user (output div_cycles, input tick_1ms, tick_10ms, tick_1s);
endinterface : sdtmr_tick_if

// ### tb/scan_driven_delay_timer_tb.sv
`timescale 1ns/1ps
`include "sdtmr_params.svh"

// ========================================
// checker attachment
bind sdtmr_top sdtmr_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_props (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .SCAN_EVAL(SCAN_EVAL), .RUNG_TRUE(RUNG_TRUE), .ENABLE_OUT(ENABLE_OUT),
  .TIMING_OUT(TIMING_OUT), .DONE_OUT(DONE_OUT), .IRQ(IRQ)
);

module scan_driven_delay_timer_tb;
  localparam logic [2:0] A_CTL = `SDTMR_OFS_CTRL_STAT;
  localparam logic [2:0] A_PRE = `SDTMR_OFS_PRESET;
  localparam logic [2:0] A_ACC = `SDTMR_OFS_ELAPSED;
  localparam logic [2:0] A_CFG = `SDTMR_OFS_CONFIG;
  localparam logic [2:0] A_STS = `SDTMR_OFS_IRQ_STATUS;
  localparam logic [2:0] A_MSK = `SDTMR_OFS_IRQ_MASK;
  localparam logic [2:0] A_DIV = `SDTMR_OFS_DIVIDER;

  logic        core_clk, nrst, wr_stb, rd_stb;
  logic        scan_eval, rung_true, en_o, tt_o, dn_o, irq;
  logic [2:0]  addr;
  logic [31:0] wdata, rdata;
  int          fails, checked, p;

  sdtmr_top #(.MS_CYCLES(4)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .SCAN_EVAL(scan_eval), .RUNG_TRUE(rung_true), .ENABLE_OUT(en_o),
    .TIMING_OUT(tt_o), .DONE_OUT(dn_o), .IRQ(irq)
  );

  sdtmr_scan_model scan (
    .clk(core_clk), .scan_eval(scan_eval), .rung_true(rung_true)
  );

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // ========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr

  // internal bits of the control word are not compared
  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk((a == A_CTL) ? (rdata & 32'hffffe000) : rdata, exp);
  endtask : rd

  task automatic flg(input logic [2:0] e);
    chk({29'h0, en_o, tt_o, dn_o}, {29'h0, e});
  endtask : flg

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic close_out;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // ========================================
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    addr = 3'h0;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(3'h7, 32'h0);
    rd(A_CTL, 32'h0);
    rd(A_PRE, 32'h0);
    wr(A_DIV, 32'h0);
    rd(A_DIV, 32'h4);
    wr(A_MSK, 32'h0);
    // on-delay, 1 ms base
    wr(A_PRE, 32'h3);
    rd(A_PRE, 32'h3);
    scan.evaluate(1'b1);
    flg(3'b110);
    idle(40);
    scan.evaluate(1'b1);
    flg(3'b101);
    chk({31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(A_STS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(A_STS, 32'h0);
    scan.evaluate(1'b0);
    flg(3'b000);
    rd(A_ACC, 32'h0);
    // off-delay
    wr(A_CFG, 32'h1);
    scan.evaluate(1'b1);
    flg(3'b101);
    scan.evaluate(1'b0);
    flg(3'b011);
    idle(40);
    scan.evaluate(1'b0);
    flg(3'b000);
    rd(A_ACC, 32'h3);
    scan.evaluate(1'b1);
    scan.evaluate(1'b0);
    rd(A_ACC, 32'h0);
    // retentive, cleared only after leaving off-delay
    wr(A_CFG, 32'h2);
    wr(A_CFG, 32'h102);
    flg(3'b000);
    scan.evaluate(1'b1);
    idle(40);
    scan.evaluate(1'b1);
    flg(3'b101);
    scan.evaluate(1'b0);
    flg(3'b001);
    rd(A_ACC, 32'h3);
    rd(A_CFG, 32'h2);
    rd(A_CTL, 32'h2000);
    wr(A_CFG, 32'h102);
    flg(3'b000);
    rd(A_ACC, 32'h0);
    // spare mode code reads back as written
    wr(A_CFG, 32'h3);
    rd(A_CFG, 32'h3);
    // each time base, on-delay, preset 2
    wr(A_PRE, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      p = (i == 0) ? 4 : (i == 1) ? 40 : 4000;
      wr(A_CFG, 32'(i) << 2);
      scan.evaluate(1'b0);
      scan.evaluate(1'b1);
      idle(p - 4);
      scan.evaluate(1'b1);
      flg(3'b110);
      idle(2 * p);
      scan.evaluate(1'b1);
      flg(3'b101);
    end
    // done and timing rose again, done unmasked
    chk({31'h0, irq}, 32'h1);
    rd(A_STS, 32'h3);
    // scan gap beyond the limit saturates pending ticks
    wr(A_CFG, 32'h0);
    idle(10300);
    rd(A_STS, 32'h4);
    chk({31'h0, irq}, 32'h0);
    close_out();
  end
endmodule : scan_driven_delay_timer_tb

// ### tb/sdtmr_properties.sv
`timescale 1ns/1ps
`include "sdtmr_params.svh"

// ========================================
// port checker for the delay timer
module sdtmr_properties #(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 32
) (
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR_STB,
  input wire logic              RD_STB,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              SCAN_EVAL,
  input wire logic              RUNG_TRUE,
  input wire logic              ENABLE_OUT,
  input wire logic              TIMING_OUT,
  input wire logic              DONE_OUT,
  input wire logic              IRQ
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  // ========================================
  // register port
  property p_rd_idle;
    !$past(RD_STB) |-> RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");

  property p_acc_range;
    $past(RD_STB) && $past(ADDR) == `SDTMR_OFS_ELAPSED |->
      RDATA[31:15] == 17'h0;
  endproperty
  a_acc_range: assert property (p_acc_range)
    else $error("elapsed count above range");

  property p_preset_back;
    WR_STB && ADDR == `SDTMR_OFS_PRESET ##2
      RD_STB && ADDR == `SDTMR_OFS_PRESET |=>
      RDATA == {17'h0, $past(WDATA[14:0], 3)};
  endproperty
  a_preset_back: assert property (p_preset_back)
    else $error("preset not read back");

  property p_clear;
    WR_STB && ADDR == `SDTMR_OFS_CONFIG && WDATA[8] && !SCAN_EVAL |=>
      !DONE_OUT && !TIMING_OUT;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left a flag set");

  property p_mask_off;
    WR_STB && ADDR == `SDTMR_OFS_IRQ_MASK && WDATA[2:0] == 3'h0 |=> !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt with all events masked");

  // ========================================
  // flags
  property p_enable;
    SCAN_EVAL |=> ENABLE_OUT == $past(RUNG_TRUE);
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable does not follow rung");

  property p_tt_dn;
    TIMING_OUT && ENABLE_OUT |-> !DONE_OUT;
  endproperty
  a_tt_dn: assert property (p_tt_dn)
    else $error("timing and done together");

  property p_hold;
    !$past(SCAN_EVAL) && !$past(WR_STB) |->
      $stable({ENABLE_OUT, TIMING_OUT, DONE_OUT});
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags moved without evaluation");
endmodule : sdtmr_properties

// ### tb/sdtmr_scan_model.sv
`timescale 1ns/1ps

// ========================================
// controller scan evaluating one rung
module sdtmr_scan_model (
  input  wire logic clk,
  output      logic scan_eval,
  output      logic rung_true
);
  // idle between evaluations
  initial
  begin
    scan_eval = 1'b0;
    rung_true = 1'b0;
  end

  // one evaluation; the test's last scan gap runs past 2.55 s to force an overrun
  task automatic evaluate(input logic rung);
    @(posedge clk);
    scan_eval <= 1'b1;
    rung_true <= rung;
    @(posedge clk);
    scan_eval <= 1'b0;
    rung_true <= ~rung;
    @(posedge clk);
    #1;
  endtask : evaluate
endmodule : sdtmr_scan_model
